// >>> tec_counters.sv
// tec_counters: clear-on-read error counters of one t1 channel
// assumes an avalon-mm master and event pulses on i_ref_clk
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module tec_counters (
	// clock, reset and enable
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_nrst,
	input  wire logic                    i_clk_en,
	// avalon-mm slave
	input  wire logic [15:0]             i_avs_address,
	input  wire logic                    i_avs_read,
	input  wire logic                    i_avs_write,
	input  wire logic [31:0]             i_avs_writedata,
	input  wire logic [3:0]              i_avs_byteenable,
	output logic      [31:0]             o_avs_readdata,
	output logic                         o_avs_waitrequest,
	// error events
	input  wire tec_pkg::tec_evt_t       i_evt,
	// interrupt
	output logic                         o_irq
);
	localparam logic [15:0] A_XZ_HIGH = {tec_pkg::TEC_IDX_EXCESS_ZERO_COUNT_HIGH, 2'b00};
	localparam logic [15:0] A_XZ_LOW  = {tec_pkg::TEC_IDX_EXCESS_ZERO_COUNT_LOW, 2'b00};
	localparam logic [15:0] A_LINK2   = {tec_pkg::TEC_IDX_LINK2_CHECKSUM_ERRORS, 2'b00};
	localparam logic [15:0] A_LINK3   = {tec_pkg::TEC_IDX_LINK3_CHECKSUM_ERRORS, 2'b00};
	localparam logic [15:0] A_STATUS  = {tec_pkg::TEC_IDX_EVENT_STATUS, 2'b00};
	localparam logic [15:0] A_CLEAR   = {tec_pkg::TEC_IDX_EVENT_CLEAR, 2'b00};
	localparam logic [15:0] A_ENABLE  = {tec_pkg::TEC_IDX_EVENT_ENABLE, 2'b00};

	// bus handshake state
	logic        ack_r;
	logic        ack_nxt;
	logic        take;
	logic        take_rd;
	logic        take_wr;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// lower byte snapshot
	logic [7:0]  snap_r;
	logic [7:0]  snap_nxt;
	logic        snap_vld_r;
	logic        snap_vld_nxt;

	// counter control and state
	logic        xz_restart;
	logic        link2_restart;
	logic        link3_restart;
	logic [15:0] xz_count;
	logic [7:0]  link2_count;
	logic [7:0]  link3_count;

	// event status access
	logic        clr_wr;
	logic        en_wr;
	logic [2:0]  evt_set;
	logic [2:0]  evt_status;
	logic [2:0]  evt_enable;

	// request taken on the first cycle it is seen with i_clk_en high
	assign take    = (i_avs_read || i_avs_write) && !ack_r && i_clk_en;
	assign take_rd = take && i_avs_read;
	assign take_wr = take && i_avs_write;

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (!ack_r || !i_clk_en);
	assign o_avs_readdata    = rdata_r;

	// read decode and side effects
	always_comb begin
		ack_nxt       = take;
		rdata_nxt     = rdata_r;
		snap_nxt      = snap_r;
		snap_vld_nxt  = snap_vld_r;
		xz_restart    = 1'b0;
		link2_restart = 1'b0;
		link3_restart = 1'b0;
		if (take_rd) begin
			if (i_avs_address == A_XZ_HIGH) begin
				// (RQ3) upper byte read
				rdata_nxt    = {24'h00_0000, xz_count[15:8]};
				// (RQ8) snapshot and restart
				snap_nxt     = xz_count[7:0];
				snap_vld_nxt = 1'b1;
				// (RQ2) clear on read
				xz_restart   = 1'b1;
			end else if (i_avs_address == A_XZ_LOW) begin
				// (RQ5) pair completes here
				if (snap_vld_r) begin
					rdata_nxt = {24'h00_0000, snap_r};
				end else begin
					rdata_nxt = {24'h00_0000, xz_count[7:0]};
				end
				snap_vld_nxt = 1'b0;
			end else if (i_avs_address == A_LINK2) begin
				rdata_nxt     = {24'h00_0000, link2_count};
				// (RQ2) clear on read
				link2_restart = 1'b1;
			end else if (i_avs_address == A_LINK3) begin
				rdata_nxt     = {24'h00_0000, link3_count};
				// (RQ2) clear on read
				link3_restart = 1'b1;
			end else if (i_avs_address == A_STATUS) begin
				rdata_nxt = {29'h0, evt_status};
			end else if (i_avs_address == A_ENABLE) begin
				rdata_nxt = {29'h0, evt_enable};
			end else begin
				rdata_nxt = tec_pkg::TEC_RDATA_RST;
			end
		end else if (take_wr) begin
			rdata_nxt = tec_pkg::TEC_RDATA_RST;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_r      <= 1'b0;
			rdata_r    <= tec_pkg::TEC_RDATA_RST;
			snap_r     <= tec_pkg::TEC_LINK_RST;
			snap_vld_r <= 1'b0;
		end else if (i_clk_en) begin
			ack_r      <= ack_nxt;
			rdata_r    <= rdata_nxt;
			snap_r     <= snap_nxt;
			snap_vld_r <= snap_vld_nxt;
		end
	end

	// register writes, byte lane 0 only
	assign clr_wr = take_wr && i_avs_byteenable[0] && (i_avs_address == A_CLEAR);
	assign en_wr  = take_wr && i_avs_byteenable[0] && (i_avs_address == A_ENABLE);

	// (RQ1) excessive-zero counter
	tec_sat_counter #(
		.W(tec_pkg::TEC_XZ_W)
	) u_xz_cnt (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_inc     (i_evt.excess_zero),
		.i_restart (xz_restart),
		.o_count   (xz_count)
	);

	// (RQ6) link 2 checksum errors
	tec_sat_counter #(
		.W(tec_pkg::TEC_LINK_W)
	) u_link2_cnt (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_inc     (i_evt.link2_fcs_err),
		.i_restart (link2_restart),
		.o_count   (link2_count)
	);

	// (RQ7) link 3 checksum errors
	tec_sat_counter #(
		.W(tec_pkg::TEC_LINK_W)
	) u_link3_cnt (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_inc     (i_evt.link3_fcs_err),
		.i_restart (link3_restart),
		.o_count   (link3_count)
	);

	// event flags
	always_comb begin
		evt_set                         = tec_pkg::TEC_EVT_RST;
		evt_set[tec_pkg::TEC_BIT_XZ]    = i_evt.excess_zero;
		evt_set[tec_pkg::TEC_BIT_LINK2] = i_evt.link2_fcs_err;
		evt_set[tec_pkg::TEC_BIT_LINK3] = i_evt.link3_fcs_err;
	end

	tec_evt_status #(
		.N(tec_pkg::TEC_EVT_N)
	) u_evt (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_clk_en  (i_clk_en),
		.i_set     (evt_set),
		.i_clr_wr  (clr_wr),
		.i_en_wr   (en_wr),
		.i_wdata   (i_avs_writedata[2:0]),
		.o_status  (evt_status),
		.o_enable  (evt_enable),
		.o_irq     (o_irq)
	);

	// checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence s_rd(logic [15:0] a);
		take_rd && (i_avs_address == a);
	endsequence

	sequence s_quiet;
		i_clk_en && !take_rd;
	endsequence

	sequence s_wr(logic [15:0] a);
		take_wr && i_avs_byteenable[0] && (i_avs_address == a);
	endsequence

	a_xz_increment: assert property ( // (RQ1)
		s_quiet ##0 (i_evt.excess_zero && (xz_count != 16'hFFFF))
		|=> xz_count == $past(xz_count) + 16'h0001
	) else $error("excess zero count did not step");

	a_xz_restart: assert property ( // (RQ2)
		s_rd(A_XZ_HIGH)
		|=> xz_count == ($past(i_evt.excess_zero) ? 16'h0001 : 16'h0000)
	) else $error("excess zero count not restarted by upper read");

	a_high_byte: assert property ( // (RQ3)
		s_rd(A_XZ_HIGH)
		|=> !o_avs_waitrequest && (o_avs_readdata == {24'h00_0000, $past(xz_count[15:8])})
	) else $error("upper byte read data wrong");

	a_low_pair: assert property ( // (RQ5)
		s_rd(A_XZ_HIGH) ##1 (!take [*2]) ##1 s_rd(A_XZ_LOW)
		|=> o_avs_readdata[7:0] == $past(xz_count[7:0], 4)
	) else $error("lower byte not from snapshot");

	a_low_alone: assert property ( // (RQ8)
		s_rd(A_XZ_LOW) ##0 (!snap_vld_r && !i_evt.excess_zero)
		|=> (xz_count == $past(xz_count)) && (o_avs_readdata[7:0] == $past(xz_count[7:0]))
	) else $error("lone lower read changed count");

	a_link2_count: assert property ( // (RQ6)
		s_quiet ##0 (i_evt.link2_fcs_err && (link2_count != 8'hFF))
		|=> link2_count == $past(link2_count) + 8'h01
	) else $error("link 2 count did not step");

	a_link3_clear: assert property ( // (RQ7)
		s_rd(A_LINK3) ##0 !i_evt.link3_fcs_err
		|=> (link3_count == 8'h00) && (o_avs_readdata[7:0] == $past(link3_count))
	) else $error("link 3 count not cleared by read");

	a_link2_hold: assert property ( // (RQ8)
		s_quiet ##0 (link2_count == 8'hFF)
		|=> link2_count == 8'hFF
	) else $error("link 2 count wrapped");

	a_bus_wait: assert property (
		take |-> o_avs_waitrequest ##1 !o_avs_waitrequest
	) else $error("answer not one cycle after take");

	a_irq_event: assert property (
		i_clk_en && i_evt.link3_fcs_err && evt_enable[tec_pkg::TEC_BIT_LINK3] && !en_wr
		|=> o_irq
	) else $error("enabled event raised no interrupt");

	a_xz_quiet: assert property ( // (RQ1)
		s_quiet ##0 !i_evt.excess_zero
		|=> xz_count == $past(xz_count)
	) else $error("excess zero count moved without event");

	a_xz_saturate: assert property ( // (RQ8)
		s_quiet ##0 (xz_count == 16'hFFFF)
		|=> xz_count == 16'hFFFF
	) else $error("excess zero count wrapped");

	a_snap_take: assert property ( // (RQ8)
		s_rd(A_XZ_HIGH)
		|=> snap_vld_r && (snap_r == $past(xz_count[7:0]))
	) else $error("lower byte snapshot not taken");

	a_low_read: assert property ( // (RQ3)
		s_rd(A_XZ_LOW) ##0 snap_vld_r
		|=> (o_avs_readdata == {24'h00_0000, $past(snap_r)}) && !snap_vld_r
	) else $error("lower byte read data wrong");

	a_low_keeps: assert property ( // (RQ5)
		s_rd(A_XZ_LOW) ##0 !i_evt.excess_zero
		|=> xz_count == $past(xz_count)
	) else $error("lower byte read changed count");

	a_link2_quiet: assert property ( // (RQ6)
		s_quiet ##0 !i_evt.link2_fcs_err
		|=> link2_count == $past(link2_count)
	) else $error("link 2 count moved without event");

	a_link2_clear: assert property ( // (RQ2)
		s_rd(A_LINK2) ##0 !i_evt.link2_fcs_err
		|=> (link2_count == 8'h00) && (o_avs_readdata[7:0] == $past(link2_count))
	) else $error("link 2 count not cleared by read");

	a_link3_count: assert property ( // (RQ7)
		s_quiet ##0 (i_evt.link3_fcs_err && (link3_count != 8'hFF))
		|=> link3_count == $past(link3_count) + 8'h01
	) else $error("link 3 count did not step");

	a_link3_hold: assert property ( // (RQ8)
		s_quiet ##0 (link3_count == 8'hFF)
		|=> link3_count == 8'hFF
	) else $error("link 3 count wrapped");

	a_freeze_count: assert property (
		!i_clk_en
		|=> (xz_count == $past(xz_count)) && (link2_count == $past(link2_count))
			&& (link3_count == $past(link3_count))
	) else $error("counter moved with clock enable low");

	a_freeze_status: assert property (
		!i_clk_en
		|=> (evt_status == $past(evt_status)) && (evt_enable == $past(evt_enable))
	) else $error("event state moved with clock enable low");

	a_status_set: assert property (
		i_clk_en && i_evt.excess_zero
		|=> evt_status[tec_pkg::TEC_BIT_XZ]
	) else $error("event status bit not set");

	a_status_clear: assert property (
		s_wr(A_CLEAR) ##0 (i_avs_writedata[tec_pkg::TEC_BIT_LINK3] && !i_evt.link3_fcs_err)
		|=> !evt_status[tec_pkg::TEC_BIT_LINK3]
	) else $error("event status bit not cleared");

	a_status_read: assert property (
		s_rd(A_STATUS)
		|=> o_avs_readdata == {29'h0, $past(evt_status)}
	) else $error("status read data wrong");

	a_enable_write: assert property (
		s_wr(A_ENABLE)
		|=> evt_enable == $past(i_avs_writedata[2:0])
	) else $error("enable register not written");

	a_enable_ignore: assert property (
		take_wr && !i_avs_byteenable[0]
		|=> evt_enable == $past(evt_enable)
	) else $error("write without byte lane 0 took effect");

	a_write_data: assert property (
		take_wr
		|=> o_avs_readdata == tec_pkg::TEC_RDATA_RST
	) else $error("read data not cleared by write");

	a_data_stand: assert property (
		!take
		|=> o_avs_readdata == $past(o_avs_readdata)
	) else $error("read data changed without request");

endmodule : tec_counters

// >>> tec_pkg.sv
// tec_pkg: register map, reset values and shared types of the t1 error counters
// assumes a 16-bit avalon-mm byte address space and 32-bit data, one aligned word per register
// Functional notes
// (RQ1) count every receive excessive-zero violation in a 16-bit counter
// (RQ2) each counter clears when read, counting events since its previous read
// (RQ3) upper register shows count bits 15..8, lower register bits 7..0
// (RQ4) host reads the upper byte before the lower byte for a coherent count
// (RQ5) host clears the 16-bit count only by reading upper then lower byte; here the upper read alone restarts it
// (RQ6) count link controller 2 frame-check errors in an 8-bit counter
// (RQ7) count link controller 3 frame-check errors in a separate 8-bit counter
// (RQ8) upper read snapshots lower byte and restarts; counters saturate at all ones
package tec_pkg;

	// register indices, byte address is four times the index
	localparam logic [13:0] TEC_IDX_EXCESS_ZERO_COUNT_HIGH = 14'h0910;
	localparam logic [13:0] TEC_IDX_EXCESS_ZERO_COUNT_LOW  = 14'h0911;
	localparam logic [13:0] TEC_IDX_LINK2_CHECKSUM_ERRORS  = 14'h091C;
	localparam logic [13:0] TEC_IDX_LINK3_CHECKSUM_ERRORS  = 14'h092C;
	localparam logic [13:0] TEC_IDX_EVENT_STATUS           = 14'h0930;
	localparam logic [13:0] TEC_IDX_EVENT_CLEAR            = 14'h0931;
	localparam logic [13:0] TEC_IDX_EVENT_ENABLE           = 14'h0932;

	// widths
	localparam int          TEC_ADDR_W    = 16;
	localparam int          TEC_DATA_W    = 32;
	localparam int          TEC_XZ_W      = 16;
	localparam int          TEC_LINK_W    = 8;
	localparam int          TEC_EVT_N     = 3;

	// event bit positions in status, clear and enable registers
	localparam int          TEC_BIT_XZ    = 0;
	localparam int          TEC_BIT_LINK2 = 1;
	localparam int          TEC_BIT_LINK3 = 2;

	// values after reset
	localparam logic [15:0] TEC_XZ_RST    = 16'h0000;
	localparam logic [7:0]  TEC_LINK_RST  = 8'h00;
	localparam logic [2:0]  TEC_EVT_RST   = 3'h0;
	localparam logic [31:0] TEC_RDATA_RST = 32'h0000_0000;

	// bus answer latency in cycles after the request is taken
	localparam int          TEC_WAIT_CYC  = 1;

	// event pulses from the receive framer and link controllers
	typedef struct packed {
		logic link3_fcs_err;
		logic link2_fcs_err;
		logic excess_zero;
	} tec_evt_t;

endpackage : tec_pkg

// >>> tec_sat_counter.sv
// tec_sat_counter: event counter that restarts on request and holds at all ones
// assumes one clock domain and one-cycle increment pulses
`timescale 1ns/10ps
module tec_sat_counter #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_clk_en,
	// control
	input  wire logic         i_inc,
	input  wire logic         i_restart,
	// count
	output logic [W-1:0]      o_count
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic [W-1:0] base;

	// (RQ8) saturate, event wins
	always_comb begin
		base      = i_restart ? '0 : count_r;
		count_nxt = base;
		if (i_inc && (base != '1)) begin
			count_nxt = base + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count_r <= '0;
		end else if (i_clk_en) begin
			count_r <= count_nxt;
		end
	end

	assign o_count = count_r;
endmodule : tec_sat_counter

// >>> tec_evt_status.sv
// tec_evt_status: sticky event status, write-one-to-clear, enable and irq
// assumes one clock domain; set and clear in one cycle leave the bit set
`timescale 1ns/10ps
module tec_evt_status #(
	parameter int N = 3
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_clk_en,
	// events and software access
	input  wire logic [N-1:0] i_set,
	input  wire logic         i_clr_wr,
	input  wire logic         i_en_wr,
	input  wire logic [N-1:0] i_wdata,
	// state
	output logic [N-1:0]      o_status,
	output logic [N-1:0]      o_enable,
	output logic              o_irq
);
	logic [N-1:0] status_r;
	logic [N-1:0] status_nxt;
	logic [N-1:0] enable_r;
	logic [N-1:0] enable_nxt;

	// set wins over clear
	always_comb begin
		status_nxt = (status_r & ~(i_clr_wr ? i_wdata : '0)) | i_set;
		enable_nxt = i_en_wr ? i_wdata : enable_r;
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			status_r <= '0;
			enable_r <= '0;
		end else if (i_clk_en) begin
			status_r <= status_nxt;
			enable_r <= enable_nxt;
		end
	end

	assign o_status = status_r;
	assign o_enable = enable_r;
	assign o_irq    = |(status_r & enable_r);
endmodule : tec_evt_status

// >>> tb_t1_error_event_counters.sv
// tb_t1_error_event_counters: self-checking bench for the clear-on-read error counters
// assumes tec_pkg and the counter modules are compiled first; one 50 MHz clock
`timescale 1ns/10ps
module tb_t1_error_event_counters;
	localparam logic [13:0] HI = tec_pkg::TEC_IDX_EXCESS_ZERO_COUNT_HIGH;
	localparam logic [13:0] LO = tec_pkg::TEC_IDX_EXCESS_ZERO_COUNT_LOW;
	localparam logic [13:0] L2 = tec_pkg::TEC_IDX_LINK2_CHECKSUM_ERRORS;
	localparam logic [13:0] L3 = tec_pkg::TEC_IDX_LINK3_CHECKSUM_ERRORS;
	localparam logic [13:0] ST = tec_pkg::TEC_IDX_EVENT_STATUS;
	localparam logic [13:0] CL = tec_pkg::TEC_IDX_EVENT_CLEAR;
	localparam logic [13:0] EN = tec_pkg::TEC_IDX_EVENT_ENABLE;

	logic              i_ref_clk;
	logic              i_nrst;
	logic              i_clk_en;
	logic [15:0]       i_avs_address;
	logic              i_avs_read;
	logic              i_avs_write;
	logic [31:0]       i_avs_writedata;
	logic [3:0]        i_avs_byteenable;
	logic [31:0]       o_avs_readdata;
	logic              o_avs_waitrequest;
	tec_pkg::tec_evt_t i_evt;
	logic              o_irq;
	int                error_cnt;
	int                samples_checked;
	int                cnt [3];
	logic [31:0]       q;
	logic [13:0]       regs [4];
	int                m;
	int                n;

	tec_counters u_tec_counters (
		.i_ref_clk         (i_ref_clk),
		.i_nrst            (i_nrst),
		.i_clk_en          (i_clk_en),
		.i_avs_address     (i_avs_address),
		.i_avs_read        (i_avs_read),
		.i_avs_write       (i_avs_write),
		.i_avs_writedata   (i_avs_writedata),
		.i_avs_byteenable  (i_avs_byteenable),
		.o_avs_readdata    (o_avs_readdata),
		.o_avs_waitrequest (o_avs_waitrequest),
		.i_evt             (i_evt),
		.o_irq             (o_irq)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	// expected count after n events in a w-bit saturating counter
	function automatic logic [31:0] sat(input int k, input int w);
		return (k > (1 << w) - 1) ? 32'((1 << w) - 1) : 32'(k);
	endfunction : sat

	task automatic conclude;
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask : chk_rd

	task automatic chk_irq(input logic exp);
		@(negedge i_ref_clk);
		samples_checked++;
		if (o_irq !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: irq %b, expected %b", $time, o_irq, exp);
		end
	endtask : chk_irq

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
			input logic [3:0] be);
		@(posedge i_ref_clk);
		i_avs_address    <= {idx, 2'b00};
		i_avs_read       <= !wr;
		i_avs_write      <= wr;
		i_avs_writedata  <= wd;
		i_avs_byteenable <= be;
		@(posedge i_ref_clk);
		while (o_avs_waitrequest !== 1'b0)
			@(posedge i_ref_clk);
		q = o_avs_readdata;
		i_avs_read  <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0, 4'hF);
		chk_rd(q, exp);
	endtask : rd_chk

	task automatic ev(input logic [2:0] msk, input int k);
		repeat (k) begin
			@(posedge i_ref_clk);
			i_evt <= msk;
		end
		@(posedge i_ref_clk);
		i_evt <= 3'h0;
		for (int b = 0; b < 3; b++)
			if (msk[b])
				cnt[b] += k;
	endtask : ev

	initial begin
		repeat (90000) @(posedge i_ref_clk);
		error_cnt++;
		conclude();
	end

	initial begin
		i_nrst = 1'b0;
		i_clk_en = 1'b1;
		i_avs_address = 16'h0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'hF;
		i_evt = 3'h0;
		error_cnt = 0;
		samples_checked = 0;
		cnt = '{0, 0, 0};
		regs = '{HI, LO, L2, L3};
		void'($urandom(32'h0B36));
		repeat (4) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		// clock enable low freezes counters and status
		@(posedge i_ref_clk);
		i_clk_en <= 1'b0;
		i_evt    <= 3'h7;
		repeat (6) @(posedge i_ref_clk);
		i_clk_en <= 1'b1;
		i_evt    <= 3'h0;
		for (int i = 0; i < 4; i++)
			rd_chk(regs[i], 32'h0);
		rd_chk(ST, 32'h0);
		repeat (8) begin
			m = $urandom % 8;
			n = $urandom % 40;
			ev(m[2:0], n);
		end
		rd_chk(HI, sat(cnt[0], 16) >> 8);
		rd_chk(LO, sat(cnt[0], 16) & 32'hFF);
		rd_chk(L2, sat(cnt[1], 8));
		rd_chk(L3, sat(cnt[2], 8));
		for (int i = 0; i < 4; i++)
			rd_chk(regs[i], 32'h0);
		n = 300 + $urandom % 500;
		ev(3'h1, n);
		rd_chk(HI, 32'(n >> 8));
		ev(3'h1, 5);
		rd_chk(LO, 32'(n & 8'hFF));
		rd_chk(HI, 32'h0);
		rd_chk(LO, 32'h5);
		ev(3'h1, 7);
		rd_chk(LO, 32'h7);
		rd_chk(HI, 32'h0);
		rd_chk(LO, 32'h7);
		ev(3'h1, 3);
		// event in the cycle the upper read is taken
		fork
			bus(1'b0, HI, 32'h0, 4'hF);
			begin
				@(posedge i_ref_clk);
				i_evt <= 3'h1;
				@(posedge i_ref_clk);
				i_evt <= 3'h0;
			end
		join
		chk_rd(q, 32'h0);
		rd_chk(LO, 32'h3);
		rd_chk(HI, 32'h0);
		rd_chk(LO, 32'h1);
		ev(3'h6, 300);
		rd_chk(L2, 32'hFF);
		rd_chk(L3, 32'hFF);
		ev(3'h1, 65540);
		rd_chk(HI, 32'hFF);
		rd_chk(LO, 32'hFF);
		bus(1'b1, EN, 32'h7, 4'hF);
		chk_irq(1'b1);
		bus(1'b1, CL, 32'h7, 4'hF);
		rd_chk(ST, 32'h0);
		chk_irq(1'b0);
		bus(1'b1, EN, 32'h0, 4'h0);
		rd_chk(EN, 32'h7);
		bus(1'b1, EN, 32'h3, 4'hF);
		ev(3'h4, 1);
		rd_chk(ST, 32'h4);
		chk_irq(1'b0);
		bus(1'b1, EN, 32'h4, 4'hF);
		chk_irq(1'b1);
		bus(1'b1, CL, 32'h4, 4'hF);
		chk_irq(1'b0);
		ev(3'h4, 1);
		chk_irq(1'b1);
		rd_chk(L3, 32'h2);
		rd_chk(14'h0900, 32'h0);
		rd_chk(CL, 32'h0);
		conclude();
	end
endmodule : tb_t1_error_event_counters
